/* File: ccs_map.svh */
// Summary of operation
// - On the internal oscillator clock the watchdog, the clock monitor and timer H1 on the internal_osc_freq/2^7 clock may run; general peripherals stop.
// - External-clock peripherals may also run on the internal oscillator clock, except timer 00 on external count edges.
// - On the subsystem clock the high-speed oscillator stops by the control bit, or in STOP while the main clock status is set; the stop bit has no effect.
// - With the external RC clock strapped there is no stabilization wait and the clock may switch at once.
// - Status bits are set one by one from the shortest interval as each elapses and stay at 1 until the oscillator stops.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// Register offsets
`define CCS_A_PROC_CLK_CTRL   8'h00
`define CCS_A_MAIN_MODE       8'h01
`define CCS_A_MAIN_OSC_CTRL   8'h02
`define CCS_A_STAB_STATUS     8'h03
`define CCS_A_STAB_SELECT     8'h04
`define CCS_A_PERIPH_REQ      8'h05

// Field positions
`define CCS_B_OSC_CTRL        7
`define CCS_B_SRC_SEL         4
`define CCS_B_MAIN_SRC        0
`define CCS_B_MAIN_STS        1
`define CCS_B_HS_STOP         7
`define CCS_B_REQ_WDT         0
`define CCS_B_REQ_CLKMON      1
`define CCS_B_REQ_TMH1        2
`define CCS_B_REQ_TMH1_DIV    3
`define CCS_B_REQ_EXTCLK      4
`define CCS_B_REQ_TZZ         5
`define CCS_B_REQ_TZZ_EDGE    6
`define CCS_B_REQ_GENERAL     7

// Widths and reset values
`define CCS_NSTAGE            5
`define CCS_CNT_W             17
`define CCS_SEL_W             3
`define CCS_RST_BYTE          8'h00
`define CCS_RST_SEL           3'h5
`define CCS_SEL_MIN           3'h1
`define CCS_ZERO_BYTE         8'h00

`endif

/* File: ccs_pkg.sv */
package ccs_pkg;
    `include "ccs_map.svh"

    typedef logic [7:0]                ccs_byte_t;
    typedef logic [`CCS_CNT_W-1:0]     ccs_cnt_t;
    typedef logic [`CCS_NSTAGE-1:0]    ccs_stage_t;
    typedef logic [`CCS_SEL_W-1:0]     ccs_sel_t;

    // Gray along run -> stop -> wake
    typedef enum logic [1:0] {
        CCS_RUN  = 2'b00,
        CCS_STOP = 2'b01,
        CCS_WAKE = 2'b11
    } ccs_pwr_e;
endpackage

/* File: ccs_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_sync
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Level
    input  wire logic din,
    output var  logic dout
);
    logic meta_q;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: ccs_stab_stage.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_stab_stage
    import ccs_pkg::*;
#(
    parameter ccs_cnt_t THRESH = ccs_cnt_t'(2048)
)
(
    // Clock and reset
    input  wire logic     mclk,
    input  wire logic     reset,
    // Counter view
    input  wire logic     clear,
    input  wire logic     allow,
    input  wire ccs_cnt_t count,
    // Sticky status bit
    output var  logic     flag
);
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            flag <= 1'b0;
        else if (clear)
            flag <= 1'b0;
        else if (allow && count >= THRESH)
            flag <= 1'b1;
    end
endmodule
`default_nettype wire

/* File: ccs_top.sv */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_map.svh"
module ccs_top
    import ccs_pkg::*;
#(
    parameter ccs_cnt_t STAB_T0 = ccs_cnt_t'(2048),
    parameter ccs_cnt_t STAB_T1 = ccs_cnt_t'(8192),
    parameter ccs_cnt_t STAB_T2 = ccs_cnt_t'(16384),
    parameter ccs_cnt_t STAB_T3 = ccs_cnt_t'(32768),
    parameter ccs_cnt_t STAB_T4 = ccs_cnt_t'(65536)
)
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      reset,
    // Register port
    input  wire ccs_byte_t addr,
    input  wire ccs_byte_t wdata,
    input  wire logic      wr,
    input  wire logic      rd,
    output var  ccs_byte_t rdata,
    // Strap pin
    input  wire logic      rc_mode_pin,
    // Standby control
    input  wire logic      stop_req,
    input  wire logic      stop_release,
    // Clock control
    output var  logic      hs_osc_stop,
    output var  logic      cpu_on_subsystem,
    output var  logic      cpu_on_hs_clock,
    output var  logic      in_stop,
    // Peripheral run enables
    output var  logic      wdt_run,
    output var  logic      clkmon_run,
    output var  logic      tmh1_run,
    output var  logic      extclk_periph_run,
    output var  logic      timer_zero_zero_run,
    output var  logic      general_periph_run
);
    ccs_byte_t  proc_clk_ctrl_q;
    logic       main_source_select_q;
    logic       main_clock_status_q;
    logic       hs_osc_stop_bit_q;
    ccs_sel_t   stab_time_select_q;
    ccs_byte_t  periph_req_q;
    ccs_pwr_e   pwr_q;
    logic       post_stop_q;
    ccs_cnt_t   cnt_q;
    ccs_stage_t stab_status_counter;
    ccs_stage_t allow;
    logic       rc_mode;
    logic       cpu_clock_source_sel;
    logic       main_osc_ctrl_bit;
    logic       osc_off;
    logic       cnt_clear;
    logic       limit_hit;
    logic       hs_stable;
    logic       on_internal;
    logic       wr_css;
    int unsigned sel_idx;

    assign cpu_clock_source_sel = proc_clk_ctrl_q[`CCS_B_SRC_SEL];
    assign main_osc_ctrl_bit    = proc_clk_ctrl_q[`CCS_B_OSC_CTRL];

    // Strap synchroniser
    ccs_sync u_rc_sync
    (
        .mclk  (mclk),
        .reset (reset),
        .din   (rc_mode_pin),
        .dout  (rc_mode)
    );

    // Selected interval index
    always_comb
    begin
        sel_idx = `CCS_NSTAGE - 1;
        if (stab_time_select_q >= `CCS_SEL_MIN && stab_time_select_q <= ccs_sel_t'(`CCS_NSTAGE))
            sel_idx = 32'(stab_time_select_q) - 32'(`CCS_SEL_MIN);
    end

    // Oscillator state
    always_comb
    begin
        if (cpu_clock_source_sel)
            osc_off = main_osc_ctrl_bit;
        else
            osc_off = hs_osc_stop_bit_q;
        if (pwr_q == CCS_STOP && main_clock_status_q)
            osc_off = 1'b1;
    end

    // Stage enables and limit
    always_comb
    begin
        for (int i = 0; i < `CCS_NSTAGE; i++)
            allow[i] = !post_stop_q || (i <= sel_idx);
        limit_hit = post_stop_q ? stab_status_counter[sel_idx]
                                : stab_status_counter[`CCS_NSTAGE-1];
    end

    assign cnt_clear = osc_off;
    assign hs_stable = !osc_off && (rc_mode || stab_status_counter[sel_idx]);
    assign wr_css    = wr && addr == `CCS_A_PROC_CLK_CTRL;

    // Interval stages
    ccs_stab_stage #(.THRESH(STAB_T0)) u_st0
    (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .allow (allow[0]),
        .count (cnt_q),
        .flag  (stab_status_counter[0])
    );
    ccs_stab_stage #(.THRESH(STAB_T1)) u_st1
    (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .allow (allow[1] && stab_status_counter[0]),
        .count (cnt_q),
        .flag  (stab_status_counter[1])
    );
    ccs_stab_stage #(.THRESH(STAB_T2)) u_st2
    (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .allow (allow[2] && stab_status_counter[1]),
        .count (cnt_q),
        .flag  (stab_status_counter[2])
    );
    ccs_stab_stage #(.THRESH(STAB_T3)) u_st3
    (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .allow (allow[3] && stab_status_counter[2]),
        .count (cnt_q),
        .flag  (stab_status_counter[3])
    );
    ccs_stab_stage #(.THRESH(STAB_T4)) u_st4
    (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .allow (allow[4] && stab_status_counter[3]),
        .count (cnt_q),
        .flag  (stab_status_counter[4])
    );

    // Stabilization counter
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            cnt_q <= '0;
        else if (cnt_clear)
            cnt_q <= '0;
        else if (!limit_hit)
            cnt_q <= cnt_q + ccs_cnt_t'(1);
    end

    // Standby sequencing
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            pwr_q <= CCS_RUN;
        else
        begin
            case (pwr_q)
                CCS_RUN:
                    if (stop_req)
                        pwr_q <= CCS_STOP;
                CCS_STOP:
                    if (stop_release)
                        pwr_q <= CCS_WAKE;
                CCS_WAKE:
                    if (rc_mode || !main_clock_status_q || stab_status_counter[sel_idx])
                        pwr_q <= CCS_RUN;
                default:
                    pwr_q <= CCS_RUN;
            endcase
        end
    end

    // Release limit flag
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            post_stop_q <= 1'b0;
        else if (pwr_q == CCS_STOP && stop_release)
            post_stop_q <= 1'b1;
    end

    // Processor clock control
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            proc_clk_ctrl_q <= `CCS_RST_BYTE;
        else if (wr_css)
        begin
            proc_clk_ctrl_q <= wdata;
            if (cpu_clock_source_sel && !wdata[`CCS_B_SRC_SEL]
                && !(main_clock_status_q && main_source_select_q && hs_stable))
                proc_clk_ctrl_q[`CCS_B_SRC_SEL] <= 1'b1;
        end
    end

    // Main clock mode
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            main_source_select_q <= 1'b0;
        else if (wr && addr == `CCS_A_MAIN_MODE)
            main_source_select_q <= wdata[`CCS_B_MAIN_SRC];
    end

    // Main clock status
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            main_clock_status_q <= 1'b0;
        else if (!main_source_select_q)
            main_clock_status_q <= 1'b0;
        else if (hs_stable)
            main_clock_status_q <= 1'b1;
    end

    // High-speed oscillator stop bit
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            hs_osc_stop_bit_q <= 1'b0;
        else if (wr && addr == `CCS_A_MAIN_OSC_CTRL)
        begin
            if (!wdata[`CCS_B_HS_STOP] || !main_clock_status_q)
                hs_osc_stop_bit_q <= wdata[`CCS_B_HS_STOP];
        end
    end

    // Stabilization select
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            stab_time_select_q <= `CCS_RST_SEL;
        else if (wr && addr == `CCS_A_STAB_SELECT)
            stab_time_select_q <= wdata[`CCS_SEL_W-1:0];
    end

    // Peripheral requests
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            periph_req_q <= `CCS_RST_BYTE;
        else if (wr && addr == `CCS_A_PERIPH_REQ)
            periph_req_q <= wdata;
    end

    // Read data
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata <= `CCS_ZERO_BYTE;
        else if (rd)
        begin
            case (addr)
                `CCS_A_PROC_CLK_CTRL:
                    rdata <= proc_clk_ctrl_q;
                `CCS_A_MAIN_MODE:
                begin
                    rdata                  <= `CCS_ZERO_BYTE;
                    rdata[`CCS_B_MAIN_SRC] <= main_source_select_q;
                    rdata[`CCS_B_MAIN_STS] <= main_clock_status_q;
                end
                `CCS_A_MAIN_OSC_CTRL:
                begin
                    rdata                 <= `CCS_ZERO_BYTE;
                    rdata[`CCS_B_HS_STOP] <= hs_osc_stop_bit_q;
                end
                `CCS_A_STAB_STATUS:
                    rdata <= 8'(stab_status_counter);
                `CCS_A_STAB_SELECT:
                    rdata <= 8'(stab_time_select_q);
                `CCS_A_PERIPH_REQ:
                    rdata <= periph_req_q;
                default:
                    rdata <= `CCS_ZERO_BYTE;
            endcase
        end
        else
            rdata <= `CCS_ZERO_BYTE;
    end

    // Clock status outputs
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            hs_osc_stop      <= 1'b0;
            cpu_on_subsystem <= 1'b0;
            cpu_on_hs_clock  <= 1'b0;
            in_stop          <= 1'b0;
        end
        else
        begin
            hs_osc_stop      <= osc_off;
            cpu_on_subsystem <= cpu_clock_source_sel;
            cpu_on_hs_clock  <= main_clock_status_q && !cpu_clock_source_sel;
            in_stop          <= pwr_q == CCS_STOP;
        end
    end

    assign on_internal = !cpu_clock_source_sel && !main_clock_status_q;

    // Peripheral gating
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wdt_run            <= 1'b0;
            clkmon_run         <= 1'b0;
            tmh1_run           <= 1'b0;
            extclk_periph_run  <= 1'b0;
            timer_zero_zero_run <= 1'b0;
            general_periph_run <= 1'b0;
        end
        else
        begin
            wdt_run            <= periph_req_q[`CCS_B_REQ_WDT];
            clkmon_run         <= periph_req_q[`CCS_B_REQ_CLKMON];
            tmh1_run           <= periph_req_q[`CCS_B_REQ_TMH1]
                                  && (!on_internal || periph_req_q[`CCS_B_REQ_TMH1_DIV]);
            extclk_periph_run  <= periph_req_q[`CCS_B_REQ_EXTCLK];
            timer_zero_zero_run <= periph_req_q[`CCS_B_REQ_TZZ]
                                  && (!on_internal || !periph_req_q[`CCS_B_REQ_TZZ_EDGE]);
            general_periph_run <= periph_req_q[`CCS_B_REQ_GENERAL] && !on_internal;
        end
    end
endmodule
`default_nettype wire

/* File: ccs_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_top_props
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic      mclk,
    input wire logic      reset,
    // Register port
    input wire ccs_byte_t addr,
    input wire ccs_byte_t wdata,
    input wire logic      wr,
    input wire logic      rd,
    input wire ccs_byte_t rdata,
    // Standby and clock
    input wire logic      stop_req,
    input wire logic      stop_release,
    input wire logic      hs_osc_stop,
    input wire logic      cpu_on_subsystem,
    input wire logic      cpu_on_hs_clock,
    input wire logic      in_stop,
    // Run enables
    input wire logic      wdt_run,
    input wire logic      clkmon_run,
    input wire logic      tmh1_run,
    input wire logic      extclk_periph_run,
    input wire logic      timer_zero_zero_run,
    input wire logic      general_periph_run
);
    ccs_byte_t req_q;
    logic      internal;
    assign internal = !cpu_on_subsystem && !cpu_on_hs_clock;
    // Last written request byte
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            req_q <= 8'h00;
        else if (wr && addr == 8'h05)
            req_q <= wdata;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_settled;
        ($stable(req_q) && $stable(cpu_on_subsystem) && $stable(cpu_on_hs_clock) && !in_stop) [*3];
    endsequence
    sequence s_moc_sub;
        !wr [*3] ##1 (wr && addr == 8'h02 && cpu_on_subsystem && !in_stop) ##1 !wr [*4];
    endsequence
    property p_run_always;
        s_settled |-> wdt_run == req_q[0] && clkmon_run == req_q[1] && extclk_periph_run == req_q[4];
    endproperty
    property p_internal_gate;
        s_settled ##0 internal |->
            tmh1_run == (req_q[2] && req_q[3]) && timer_zero_zero_run == (req_q[5] && !req_q[6])
            && !general_periph_run;
    endproperty
    property p_full_gate;
        s_settled ##0 !internal |->
            tmh1_run == req_q[2] && timer_zero_zero_run == req_q[5] && general_periph_run == req_q[7];
    endproperty
    property p_moc_sub;
        s_moc_sub |-> hs_osc_stop == $past(hs_osc_stop, 5);
    endproperty
    property p_status_thermo;
        rd && addr == 8'h03 |=> ((rdata + 8'h01) & rdata) == 8'h00;
    endproperty
    property p_rdata_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    property p_stop_enter;
        $rose(in_stop) |-> $past(stop_req, 2);
    endproperty
    property p_stop_exit;
        $fell(in_stop) |-> $past(stop_release, 2);
    endproperty
    a_run_always: assert property (p_run_always) else $error("run enable wrong");
    a_internal_gate: assert property (p_internal_gate) else $error("internal gating wrong");
    a_full_gate: assert property (p_full_gate) else $error("run enable not following request");
    a_moc_sub: assert property (p_moc_sub) else $error("stop bit acted on subsystem");
    a_status_thermo: assert property (p_status_thermo) else $error("status bits out of order");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry without request");
    a_stop_exit: assert property (p_stop_exit) else $error("stop exit without release");
endmodule

bind ccs_top ccs_top_props ccs_top_props_inst (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .stop_req(stop_req), .stop_release(stop_release),
    .hs_osc_stop(hs_osc_stop), .cpu_on_subsystem(cpu_on_subsystem), .cpu_on_hs_clock(cpu_on_hs_clock),
    .in_stop(in_stop), .wdt_run(wdt_run), .clkmon_run(clkmon_run), .tmh1_run(tmh1_run),
    .extclk_periph_run(extclk_periph_run), .timer_zero_zero_run(timer_zero_zero_run),
    .general_periph_run(general_periph_run));
`default_nettype wire

/* File: cpu_clock_switch_and_osc_stop_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_clock_switch_and_osc_stop_bench;
    import ccs_pkg::*;
    logic      mclk, reset, wr, rd, rc_mode_pin, stop_req, stop_release;
    ccs_byte_t addr, wdata, rdata, v, p;
    logic      hs_osc_stop, cpu_on_subsystem, cpu_on_hs_clock, in_stop;
    logic      wdt_run, clkmon_run, tmh1_run, extclk_periph_run, timer_zero_zero_run, general_periph_run;
    int        fails, checks_done, seed;
    ccs_byte_t rst_addr [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07};
    ccs_byte_t rst_val  [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h00};

    ccs_top #(.STAB_T0(ccs_cnt_t'(4)), .STAB_T1(ccs_cnt_t'(8)), .STAB_T2(ccs_cnt_t'(12)),
        .STAB_T3(ccs_cnt_t'(16)), .STAB_T4(ccs_cnt_t'(20))) ccs_top_inst (.mclk(mclk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rc_mode_pin(rc_mode_pin),
        .stop_req(stop_req), .stop_release(stop_release), .hs_osc_stop(hs_osc_stop),
        .cpu_on_subsystem(cpu_on_subsystem), .cpu_on_hs_clock(cpu_on_hs_clock), .in_stop(in_stop),
        .wdt_run(wdt_run), .clkmon_run(clkmon_run), .tmh1_run(tmh1_run),
        .extclk_periph_run(extclk_periph_run), .timer_zero_zero_run(timer_zero_zero_run),
        .general_periph_run(general_periph_run));

    always #5 mclk = ~mclk;

    task automatic check(input ccs_byte_t seen, input ccs_byte_t exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input ccs_byte_t a, input ccs_byte_t d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input ccs_byte_t a, output ccs_byte_t d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input ccs_byte_t a, input ccs_byte_t e);
        rd_reg(a, v);
        check(v, e, "register read");
    endtask

    task automatic pulse_stop(input logic rel);
        @(posedge mclk);
        stop_release <= rel;
        stop_req     <= !rel;
        @(posedge mclk);
        stop_release <= 1'b0;
        stop_req     <= 1'b0;
        wait_cyc(2);
    endtask

    // Expected enables: general, timer_zero_zero, ext clock, tmh1, clock monitor, watchdog
    function automatic ccs_byte_t exp_run(input ccs_byte_t r, input logic intl);
        if (intl)
            return {3'h0, r[5] & ~r[6], r[4], r[2] & r[3], r[1], r[0]};
        return {2'h0, r[7], r[5], r[4], r[2], r[1], r[0]};
    endfunction

    function automatic ccs_byte_t run_pins();
        return {2'h0, general_periph_run, timer_zero_zero_run, extclk_periph_run, tmh1_run, clkmon_run, wdt_run};
    endfunction

    function automatic ccs_byte_t clk_pins();
        return {4'h0, hs_osc_stop, in_stop, cpu_on_subsystem, cpu_on_hs_clock};
    endfunction

    task automatic periph_loop(input logic intl);
        ccs_byte_t r;
        for (int i = 0; i < 8; i++)
        begin
            r = (i == 0) ? 8'hFF : (i == 1) ? 8'h24 : ccs_byte_t'($random(seed));
            wr_reg(8'h05, r);
            wait_cyc(3);
            check(run_pins(), exp_run(r, intl), "run enables");
        end
    endtask

    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end

    initial
    begin
        mclk = 1'b0;
        reset = 1'b1;
        {addr, wdata, wr, rd, rc_mode_pin, stop_req, stop_release} = '0;
        seed = 58401;
        fails = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd_chk(rst_addr[i], rst_val[i]);
        check(clk_pins(), 8'h00, "clock pins after reset");
        // Status fills from the shortest bit and stays
        p = 8'h00;
        for (int i = 0; i < 30; i++)
        begin
            rd_reg(8'h03, v);
            check({7'h00, ((v & (v + 8'h01)) == 8'h00) && ((v & p) == p)}, 8'h01, "status order");
            p = v;
        end
        check(v, 8'h1F, "status full");
        periph_loop(1'b1);
        wr_reg(8'h01, 8'h01);
        wait_cyc(4);
        rd_chk(8'h01, 8'h03);
        check(clk_pins(), 8'h01, "on high-speed clock");
        periph_loop(1'b0);
        // Stop bit refused while main clock is up
        wr_reg(8'h02, 8'h80);
        wait_cyc(3);
        rd_chk(8'h02, 8'h00);
        wr_reg(8'h01, 8'h00);
        wait_cyc(4);
        rd_chk(8'h01, 8'h00);
        wr_reg(8'h02, 8'h80);
        wait_cyc(3);
        rd_chk(8'h02, 8'h80);
        rd_chk(8'h03, 8'h00);
        check(clk_pins(), 8'h08, "oscillator stopped");
        // Subsystem clock ignores the stop bit
        wr_reg(8'h00, 8'h10);
        wait_cyc(3);
        check(clk_pins(), 8'h02, "stop bit acted");
        wr_reg(8'h02, 8'h00);
        wait_cyc(5);
        wr_reg(8'h00, 8'h90);
        wait_cyc(3);
        check(clk_pins(), 8'h0A, "control bit did not stop");
        // Return to high-speed only once main clock is ready
        wr_reg(8'h00, 8'h80);
        wait_cyc(3);
        rd_chk(8'h00, 8'h90);
        wr_reg(8'h00, 8'h10);
        wait_cyc(30);
        wr_reg(8'h01, 8'h01);
        wait_cyc(4);
        rd_chk(8'h01, 8'h03);
        wr_reg(8'h00, 8'h00);
        wait_cyc(3);
        rd_chk(8'h00, 8'h00);
        check(clk_pins(), 8'h01, "not back on high-speed clock");
        // External RC clock needs no wait
        wr_reg(8'h01, 8'h00);
        wait_cyc(4);
        wr_reg(8'h02, 8'h80);
        rc_mode_pin <= 1'b1;
        wait_cyc(4);
        wr_reg(8'h02, 8'h00);
        wr_reg(8'h01, 8'h01);
        wait_cyc(2);
        rd_chk(8'h01, 8'h03);
        rd_reg(8'h03, v);
        check({7'h00, v[4]}, 8'h00, "long wait seen");
        rc_mode_pin <= 1'b0;
        // STOP with a short selection
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h04, 8'h02);
        pulse_stop(1'b0);
        check(clk_pins(), 8'h04, "not in stop");
        pulse_stop(1'b1);
        check(clk_pins(), 8'h00, "stop not released");
        wr_reg(8'h02, 8'h80);
        wait_cyc(3);
        wr_reg(8'h02, 8'h00);
        wait_cyc(60);
        rd_chk(8'h03, 8'h03);
        // STOP on the high-speed clock, oscillator stops and refills only up to the selected stage
        wr_reg(8'h01, 8'h01);
        wait_cyc(4);
        pulse_stop(1'b0);
        check(clk_pins(), 8'h0D, "oscillator running in stop");
        pulse_stop(1'b1);
        check(clk_pins(), 8'h01, "clock pins after wake");
        wait_cyc(20);
        rd_chk(8'h03, 8'h03);
        give_verdict();
    end
endmodule
`default_nettype wire
